// [pkg/ale_pkg.sv]
package ale_pkg;

  localparam int WORD_W = 30;
  localparam int ADDR_W = 15;
  localparam int CHAN_N = 8;

  // ****************************************
  // register offsets and control fields
  // ****************************************
  localparam logic [1:0] REG_ACC = 2'h0;
  localparam logic [1:0] REG_SECOND = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_CONTROL = 2'h3;
  localparam int CTL_HALT_CLR = 0;
  localparam int CTL_IEN_CLR = 1;
  localparam int STS_BUSY = 0;
  localparam int STS_IEN = 1;
  localparam int STS_HALT = 2;
  localparam int STS_SKIP = 3;
  localparam int STS_JUMP = 4;
  localparam int STS_ILLEGAL = 5;
  localparam logic [29:0] ACC_RESET = 30'h0000_0000;
  localparam logic [29:0] SECOND_RESET = 30'h0000_0000;
  localparam logic [29:0] ONE_WORD = 30'h0000_0001;

  // ****************************************
  // opcodes (octal 24..62 as hex)
  // ****************************************
  localparam logic [5:0] OP_REPL_ADD = 6'h14;
  localparam logic [5:0] OP_REPL_SUB = 6'h15;
  localparam logic [5:0] OP_ADD_Q = 6'h16;
  localparam logic [5:0] OP_SUB_Q = 6'h17;
  localparam logic [5:0] OP_ENT_YPQ = 6'h18;
  localparam logic [5:0] OP_ENT_YMQ = 6'h19;
  localparam logic [5:0] OP_STO_APQ = 6'h1A;
  localparam logic [5:0] OP_STO_AMQ = 6'h1B;
  localparam logic [5:0] OP_REPL_YPQ = 6'h1C;
  localparam logic [5:0] OP_REPL_YMQ = 6'h1D;
  localparam logic [5:0] OP_REPL_INC = 6'h1E;
  localparam logic [5:0] OP_REPL_DEC = 6'h1F;
  localparam logic [5:0] OP_ENT_LP = 6'h20;
  localparam logic [5:0] OP_ADD_LP = 6'h21;
  localparam logic [5:0] OP_SUB_LP = 6'h22;
  localparam logic [5:0] OP_CMP_MASK = 6'h23;
  localparam logic [5:0] OP_REPL_LP = 6'h24;
  localparam logic [5:0] OP_REPL_ALP = 6'h25;
  localparam logic [5:0] OP_REPL_SLP = 6'h26;
  localparam logic [5:0] OP_STO_LP = 6'h27;
  localparam logic [5:0] OP_SEL_SET = 6'h28;
  localparam logic [5:0] OP_SEL_CPL = 6'h29;
  localparam logic [5:0] OP_SEL_CLR = 6'h2A;
  localparam logic [5:0] OP_SEL_SUB = 6'h2B;
  localparam logic [5:0] OP_RSEL_SET = 6'h2C;
  localparam logic [5:0] OP_RSEL_CPL = 6'h2D;
  localparam logic [5:0] OP_RSEL_CLR = 6'h2E;
  localparam logic [5:0] OP_RSEL_SUB = 6'h2F;
  localparam logic [5:0] OP_JUMP_ARITH = 6'h30;
  localparam logic [5:0] OP_JUMP_MAN = 6'h31;
  localparam logic [5:0] OP_JUMP_IBUF = 6'h32;

  localparam logic [1:0] BE_LOWER = 2'h1;
  localparam logic [1:0] BE_UPPER = 2'h2;
  localparam logic [1:0] BE_WHOLE = 2'h3;

  typedef enum logic [1:0] {
    ALE_IDLE = 2'h0,
    ALE_EXEC = 2'h1
  } ale_state_t;

  typedef struct packed {
    ale_state_t st;
    logic [5:0] op;
    logic [2:0] j;
    logic [2:0] k;
    logic [29:0] y;
    logic [14:0] yaddr;
    logic [29:0] a;
    logic [29:0] q;
    logic done;
    logic skip;
    logic jump;
    logic [14:0] jaddr;
    logic halt;
    logic ien;
    logic illegal;
    logic mem_we;
    logic [1:0] mem_be;
    logic [14:0] mem_addr;
    logic [29:0] mem_wdata;
    logic [29:0] rdata;
  } ale_regs_t;

  // ones-complement add with end-around carry
  function automatic logic [29:0] ale_add(input logic [29:0] x, input logic [29:0] z);
    logic [30:0] s;
    s = {1'b0, x} + {1'b0, z};
    return s[29:0] + {29'h0000_0000, s[30]};
  endfunction

  function automatic logic [29:0] ale_sub(input logic [29:0] x, input logic [29:0] z);
    return ale_add(x, ~z);
  endfunction

  function automatic logic ale_zero(input logic [29:0] x);
    return (x == 30'h0000_0000) || (x == 30'h3FFF_FFFF);
  endfunction

  // skip table shared by the add-q, subtract-q and compare-masked groups
  function automatic logic ale_skip_tab(input logic [2:0] j, input logic [29:0] a, input logic [29:0] q);
    logic r;
    r = 1'b0;
    unique case (j)
      3'h0: r = 1'b0;
      3'h1: r = 1'b1;
      3'h2: r = ~a[29];
      3'h3: r = a[29];
      3'h4: r = ale_zero(q);
      3'h5: r = ~ale_zero(q);
      3'h6: r = ~q[29];
      3'h7: r = q[29];
    endcase
    return r;
  endfunction

endpackage

// [logic/ale_exec.sv]
`timescale 1ns/1ps
module ale_exec
  import ale_pkg::*;
#(
  parameter int CHANNELS = CHAN_N
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic [29:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [29:0] reg_rdata,
  input wire logic exec_start,
  input wire logic [5:0] exec_op,
  input wire logic [2:0] exec_j,
  input wire logic [2:0] exec_k,
  input wire logic [29:0] exec_operand,
  input wire logic [14:0] exec_addr,
  input wire logic [2:0] jump_keys,
  input wire logic [2:0] stop_keys,
  input wire logic [CHANNELS-1:0] ibuf_active,
  output logic busy,
  output logic done,
  output logic skip,
  output logic jump,
  output logic [14:0] jump_addr,
  output logic halt,
  output logic int_enable,
  output logic mem_we,
  output logic [1:0] mem_be,
  output logic [14:0] mem_addr,
  output logic [29:0] mem_wdata
);

  ale_regs_t s_q;
  ale_regs_t s_d;

  // store lane select from the operand interpretation field
  function automatic logic [1:0] ale_lane(input logic [2:0] k);
    logic [1:0] v;
    v = BE_WHOLE;
    if (k == 3'h1) begin
      v = BE_LOWER;
    end else if (k == 3'h2) begin
      v = BE_UPPER;
    end
    return v;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [29:0] r;
    logic [29:0] m;
    logic wr;
    logic sk;
    logic jp;
    logic hl;
    logic ie;
    logic [1:0] be;
    r = s_q.a;
    m = s_q.y & s_q.q;
    wr = 1'b0;
    sk = 1'b0;
    jp = 1'b0;
    hl = 1'b0;
    ie = 1'b0;
    be = BE_WHOLE;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.mem_we = 1'b0;
    s_d.rdata = 30'h0000_0000;
    unique case (s_q.st)
      ALE_IDLE: begin
        if (exec_start) begin
          s_d.st = ALE_EXEC;
          s_d.op = exec_op;
          s_d.j = exec_j;
          s_d.k = exec_k;
          s_d.y = exec_operand;
          s_d.yaddr = exec_addr;
        end
      end
      ALE_EXEC: begin
        s_d.st = ALE_IDLE;
        s_d.done = 1'b1;
        s_d.illegal = 1'b0;
        case (s_q.op)
          OP_REPL_ADD: begin
            r = ale_add(s_q.a, s_q.y);
            wr = 1'b1;
          end
          OP_REPL_SUB: begin
            r = ale_sub(s_q.a, s_q.y);
            wr = 1'b1;
          end
          OP_ADD_Q, OP_SUB_Q: begin
            // only q moves; a keeps its value
            s_d.q = (s_q.op == OP_ADD_Q) ? ale_add(s_q.q, s_q.y) : ale_sub(s_q.q, s_q.y);
            sk = ale_skip_tab(s_q.j, s_q.a, s_d.q);
          end
          OP_ENT_YPQ: r = ale_add(s_q.q, s_q.y);
          OP_ENT_YMQ: r = ~ale_sub(s_q.q, s_q.y);
          OP_STO_APQ, OP_STO_AMQ: begin
            r = (s_q.op == OP_STO_APQ) ? ale_add(s_q.a, s_q.q) : ale_sub(s_q.a, s_q.q);
            wr = 1'b1;
            be = ale_lane(s_q.k);
          end
          OP_REPL_YPQ: begin
            r = ale_add(s_q.q, s_q.y);
            wr = 1'b1;
          end
          OP_REPL_YMQ: begin
            r = ~ale_sub(s_q.q, s_q.y);
            wr = 1'b1;
          end
          OP_REPL_INC: begin
            r = ale_add(ONE_WORD, s_q.y);
            wr = 1'b1;
          end
          OP_REPL_DEC: begin
            r = ~ale_sub(ONE_WORD, s_q.y);
            wr = 1'b1;
          end
          OP_ENT_LP, OP_REPL_LP: begin
            r = m;
            wr = (s_q.op == OP_REPL_LP);
            sk = (s_q.j == 3'h1) || (s_q.j == 3'h2 && ~^m) || (s_q.j == 3'h3 && ^m);
          end
          OP_ADD_LP: r = ale_add(s_q.a, m);
          OP_SUB_LP: r = ale_sub(s_q.a, m);
          OP_CMP_MASK: begin
            // trial difference feeds the skip only
            sk = ale_skip_tab(s_q.j, ale_sub(s_q.a, m), s_q.q);
          end
          OP_REPL_ALP: begin
            r = ale_add(s_q.a, m);
            wr = 1'b1;
          end
          OP_REPL_SLP: begin
            r = ale_sub(s_q.a, m);
            wr = 1'b1;
          end
          OP_STO_LP: begin
            wr = 1'b1;
            be = ale_lane(s_q.k);
          end
          OP_SEL_SET, OP_RSEL_SET: begin
            r = s_q.a | s_q.y;
            wr = (s_q.op == OP_RSEL_SET);
          end
          OP_SEL_CPL, OP_RSEL_CPL: begin
            r = s_q.a ^ s_q.y;
            wr = (s_q.op == OP_RSEL_CPL);
          end
          OP_SEL_CLR, OP_RSEL_CLR: begin
            r = s_q.a & ~s_q.y;
            wr = (s_q.op == OP_RSEL_CLR);
          end
          OP_SEL_SUB, OP_RSEL_SUB: begin
            r = (s_q.a & ~s_q.q) | m;
            wr = (s_q.op == OP_RSEL_SUB);
          end
          OP_JUMP_ARITH: begin
            unique case (s_q.j)
              3'h0: ie = 1'b1;
              3'h1: begin
                ie = 1'b1;
                jp = 1'b1;
              end
              3'h2: jp = ~s_q.q[29];
              3'h3: jp = s_q.q[29];
              3'h4: jp = ale_zero(s_q.a);
              3'h5: jp = ~ale_zero(s_q.a);
              3'h6: jp = ~s_q.a[29];
              3'h7: jp = s_q.a[29];
            endcase
          end
          OP_JUMP_MAN: begin
            jp = (s_q.j == 3'h0) || s_q.j[2] || jump_keys[s_q.j[1:0] - 2'h1];
            hl = (s_q.j == 3'h4) || (s_q.j[2] && s_q.j[1:0] != 2'h0 && stop_keys[s_q.j[1:0] - 2'h1]);
          end
          OP_JUMP_IBUF: jp = ibuf_active[s_q.j];
          default: s_d.illegal = 1'b1;
        endcase
        s_d.a = r;
        s_d.skip = sk;
        s_d.jump = jp;
        s_d.jaddr = s_q.y[14:0];
        s_d.mem_we = wr;
        s_d.mem_be = be;
        s_d.mem_addr = s_q.yaddr;
        s_d.mem_wdata = (s_q.op == OP_STO_LP) ? (s_q.a & s_q.q) : r;
      end
      default: s_d.st = ALE_IDLE;
    endcase

    // ****************************************
    // register port; a and q writable only while idle
    // ****************************************
    if (reg_wr && s_q.st == ALE_IDLE) begin
      if (reg_addr == REG_ACC) begin
        s_d.a = reg_wdata;
      end
      if (reg_addr == REG_SECOND) begin
        s_d.q = reg_wdata;
      end
    end
    if (reg_wr && reg_addr == REG_CONTROL) begin
      if (reg_wdata[CTL_HALT_CLR]) begin
        s_d.halt = 1'b0;
      end
      if (reg_wdata[CTL_IEN_CLR]) begin
        s_d.ien = 1'b0;
      end
    end
    // set beats a clear in the same cycle
    if (hl) begin
      s_d.halt = 1'b1;
    end
    if (ie) begin
      s_d.ien = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_ACC: s_d.rdata = s_q.a;
        REG_SECOND: s_d.rdata = s_q.q;
        REG_STATUS: s_d.rdata = {24'h00_0000, s_q.illegal, s_q.jump, s_q.skip, s_q.halt, s_q.ien,
                                 s_q.st != ALE_IDLE};
        REG_CONTROL: s_d.rdata = 30'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '{st: ALE_IDLE, a: ACC_RESET, q: SECOND_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy = (s_q.st != ALE_IDLE);
  assign done = s_q.done;
  assign skip = s_q.skip;
  assign jump = s_q.jump;
  assign jump_addr = s_q.jaddr;
  assign halt = s_q.halt;
  assign int_enable = s_q.ien;
  assign mem_we = s_q.mem_we;
  assign mem_be = s_q.mem_be;
  assign mem_addr = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign reg_rdata = s_q.rdata;

  // ****************************************
  // checks
  // ****************************************
  logic ibuf_sel;
  logic exec_now;
  logic [29:0] mask_now;
  assign mask_now = s_q.y & s_q.q;
  assign ibuf_sel = ibuf_active[s_q.j];
  assign exec_now = (s_q.st == ALE_EXEC);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_replace_add_store: assert property (exec_now && s_q.op == OP_REPL_ADD |=>
    mem_we && mem_wdata == s_q.a && s_q.a == ale_add($past(s_q.a), $past(s_q.y)))
    else $error("replace add did not store the new sum");
  chk_addq_keeps_acc: assert property (exec_now && (s_q.op == OP_ADD_Q || s_q.op == OP_SUB_Q) |=>
    s_q.a == $past(s_q.a) && !mem_we)
    else $error("add q disturbed the accumulator");
  chk_masked_cmp_quiet: assert property (exec_now && s_q.op == OP_CMP_MASK |=>
    s_q.a == $past(s_q.a) && s_q.q == $past(s_q.q) && !mem_we)
    else $error("compare masked changed a register");
  chk_parity_even_skip: assert property (exec_now && s_q.op == OP_ENT_LP && s_q.j == 3'h2 |=>
    done && skip == ~^s_q.a)
    else $error("even parity skip wrong");
  chk_sel_set_bits: assert property (exec_now && s_q.op == OP_SEL_SET |=>
    s_q.a == ($past(s_q.a) | $past(s_q.y)))
    else $error("selective set wrong");
  chk_jump_stop_halt: assert property (exec_now && s_q.op == OP_JUMP_MAN && s_q.j == 3'h4 |=>
    jump && halt && jump_addr == $past(s_q.y[14:0]))
    else $error("jump and stop did not halt");
  chk_ien_on_jump: assert property (exec_now && s_q.op == OP_JUMP_ARITH && s_q.j[2:1] == 2'h0 |=>
    int_enable && jump == $past(s_q.j[0]))
    else $error("interrupt enable not set");
  chk_ibuf_jump_sel: assert property (exec_now && s_q.op == OP_JUMP_IBUF |=>
    jump == $past(ibuf_sel))
    else $error("input buffer jump mismatch");
  chk_start_to_done: assert property (exec_start && !busy |-> ##2 done)
    else $error("done not two cycles after start");
  chk_replace_sub_store: assert property (exec_now && s_q.op == OP_REPL_SUB |=>
    mem_we && mem_wdata == s_q.a && s_q.a == ale_sub($past(s_q.a), $past(s_q.y)))
    else $error("replace subtract did not store the difference");
  chk_addq_second_sum: assert property (exec_now && s_q.op == OP_ADD_Q |=>
    s_q.q == ale_add($past(s_q.q), $past(s_q.y)))
    else $error("add q left a wrong second register");
  chk_addq_skip_table: assert property (exec_now && (s_q.op == OP_ADD_Q || s_q.op == OP_SUB_Q) |=>
    skip == ale_skip_tab($past(s_q.j), s_q.a, s_q.q))
    else $error("add q skip condition wrong");
  chk_enter_ymq_cpl: assert property (exec_now && s_q.op == OP_ENT_YMQ |=>
    !mem_we && s_q.a == ~ale_sub($past(s_q.q), $past(s_q.y)))
    else $error("enter y minus q wrong");
  chk_store_lane_sel: assert property (exec_now && (s_q.op == OP_STO_APQ || s_q.op == OP_STO_AMQ) |=>
    mem_we && mem_wdata == s_q.a && mem_be == ale_lane($past(s_q.k)))
    else $error("store a and q lanes wrong");
  chk_replace_ypq_sum: assert property (exec_now && s_q.op == OP_REPL_YPQ |=>
    mem_we && mem_wdata == s_q.a && s_q.a == ale_add($past(s_q.q), $past(s_q.y)))
    else $error("replace y plus q wrong");
  chk_replace_dec_word: assert property (exec_now && s_q.op == OP_REPL_DEC |=>
    mem_we && mem_wdata == s_q.a && s_q.a == ~ale_sub(ONE_WORD, $past(s_q.y)))
    else $error("replace decrement wrong");
  chk_sub_masked_acc: assert property (exec_now && s_q.op == OP_SUB_LP |=>
    !mem_we && s_q.a == ale_sub($past(s_q.a), $past(mask_now)))
    else $error("subtract masked wrong");
  chk_parity_odd_store: assert property (exec_now && s_q.op == OP_REPL_LP && s_q.j == 3'h3 |=>
    mem_we && mem_wdata == s_q.a && s_q.a == $past(mask_now) && skip == ^s_q.a)
    else $error("replace masked odd parity wrong");
  chk_replace_sub_lp: assert property (exec_now && s_q.op == OP_REPL_SLP |=>
    mem_we && mem_wdata == s_q.a && s_q.a == ale_sub($past(s_q.a), $past(mask_now)))
    else $error("replace subtract masked wrong");
  chk_store_lp_word: assert property (exec_now && s_q.op == OP_STO_LP |=>
    mem_we && s_q.a == $past(s_q.a) && mem_wdata == ($past(s_q.a) & $past(s_q.q)))
    else $error("store masked word wrong");
  chk_substitute_bits: assert property (exec_now && s_q.op == OP_SEL_SUB |=>
    !mem_we && s_q.a == (($past(s_q.a) & ~$past(s_q.q)) | $past(mask_now)))
    else $error("selective substitute wrong");
  chk_rsel_clear_store: assert property (exec_now && s_q.op == OP_RSEL_CLR |=>
    mem_we && mem_wdata == s_q.a && s_q.a == ($past(s_q.a) & ~$past(s_q.y)))
    else $error("replace selective clear wrong");
  chk_rsel_sub_store: assert property (exec_now && s_q.op == OP_RSEL_SUB |=>
    mem_we && mem_wdata == s_q.a && s_q.a == (($past(s_q.a) & ~$past(s_q.q)) | $past(mask_now)))
    else $error("replace selective substitute wrong");
  chk_acc_zero_jump: assert property (exec_now && s_q.op == OP_JUMP_ARITH && s_q.j == 3'h4 |=>
    jump == ale_zero(s_q.a) && jump_addr == $past(s_q.y[14:0]))
    else $error("jump on zero accumulator wrong");
  chk_key_two_jump: assert property (exec_now && s_q.op == OP_JUMP_MAN && s_q.j == 3'h2 |=>
    jump == $past(jump_keys[1]))
    else $error("jump key two ignored");
  chk_cmp_mask_skip: assert property (exec_now && s_q.op == OP_CMP_MASK |=>
    skip == ale_skip_tab($past(s_q.j), ale_sub(s_q.a, $past(mask_now)), s_q.q))
    else $error("compare masked skip wrong");

  cov_replace_add: cover property (exec_now && s_q.op == OP_REPL_ADD ##1 mem_we);
  cov_manual_halt: cover property (exec_now && s_q.op == OP_JUMP_MAN ##1 halt);
  cov_ibuf_jump: cover property (exec_now && s_q.op == OP_JUMP_IBUF ##1 jump);
  cov_masked_skip: cover property (exec_now && s_q.op == OP_CMP_MASK ##1 skip);

endmodule

// [tb/ale_mem_model.sv]
`timescale 1ns/1ps
module ale_mem_model (
  input wire logic clock,
  input wire logic mem_we,
  input wire logic [1:0] mem_be,
  input wire logic [14:0] mem_addr,
  input wire logic [29:0] mem_wdata,
  input wire logic [14:0] look_addr,
  output logic [29:0] look_data
);
  logic [29:0] store [0:32767];

  // ****************************************
  // core storage: each half-word lane written only when enabled
  // ****************************************
  always_ff @(posedge clock) begin
    if (mem_we) begin
      if (mem_be[0]) begin
        store[mem_addr][14:0] <= mem_wdata[14:0];
      end
      if (mem_be[1]) begin
        store[mem_addr][29:15] <= mem_wdata[29:15];
      end
    end
  end
  assign look_data = store[look_addr];
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench
  import ale_pkg::*;
;
  localparam logic [14:0] ADR = 15'h2A5C;
  localparam logic [29:0] A0 = 30'h2000_1234;
  localparam logic [29:0] Q0 = 30'h0000_0F0F;
  localparam logic [29:0] Y0 = 30'h0000_00FF;
  logic clock, rstn, reg_wr, reg_rd, exec_start, busy, done, skip, jump, halt, int_enable, mem_we;
  logic [1:0] reg_addr, mem_be;
  logic [29:0] reg_wdata, reg_rdata, exec_operand, mem_wdata, look_data;
  logic [5:0] exec_op;
  logic [2:0] exec_j, exec_k, jump_keys, stop_keys;
  logic [14:0] jump_addr, mem_addr, exec_addr;
  logic [7:0] ibuf_active;
  int fail_count = 0;
  int num_checks = 0;

  ale_exec uut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_start(exec_start), .exec_op(exec_op), .exec_j(exec_j),
    .exec_k(exec_k), .exec_operand(exec_operand), .exec_addr(exec_addr), .jump_keys(jump_keys),
    .stop_keys(stop_keys), .ibuf_active(ibuf_active), .busy(busy), .done(done), .skip(skip), .jump(jump),
    .jump_addr(jump_addr), .halt(halt), .int_enable(int_enable), .mem_we(mem_we), .mem_be(mem_be),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  ale_mem_model mem (.clock(clock), .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .look_addr(exec_addr), .look_data(look_data));

  // ****************************************
  // ones-complement reference arithmetic
  // ****************************************
  function automatic logic [29:0] oa(input logic [29:0] x, input logic [29:0] z);
    logic [30:0] s;
    s = {1'b0, x} + {1'b0, z};
    return s[29:0] + {29'h0000_0000, s[30]};
  endfunction
  function automatic logic [29:0] os(input logic [29:0] x, input logic [29:0] z);
    return oa(x, ~z);
  endfunction
  function automatic logic nz(input logic [29:0] x);
    return !(x == 30'h0000_0000 || x == 30'h3FFF_FFFF);
  endfunction
  function automatic logic sk(input logic [2:0] j, input logic [29:0] a, input logic [29:0] q);
    logic [7:0] t;
    t = {q[29], ~q[29], nz(q), ~nz(q), a[29], ~a[29], 2'h2};
    return t[j];
  endfunction
  function automatic logic [29:0] ea(input logic [5:0] op);
    case (op)
      6'h14: return oa(A0, Y0);
      6'h15: return os(A0, Y0);
      6'h18, 6'h1C: return oa(Q0, Y0);
      6'h19, 6'h1D: return ~os(Q0, Y0);
      6'h1E: return oa(30'h0000_0001, Y0);
      6'h1F: return ~os(30'h0000_0001, Y0);
      6'h20, 6'h24: return Y0 & Q0;
      6'h21, 6'h25: return oa(A0, Y0 & Q0);
      6'h22, 6'h26: return os(A0, Y0 & Q0);
      6'h28, 6'h2C: return A0 | Y0;
      6'h29, 6'h2D: return A0 ^ Y0;
      6'h2A, 6'h2E: return A0 & ~Y0;
      6'h2B, 6'h2F: return (A0 & ~Q0) | (Y0 & Q0);
      default: return A0;
    endcase
  endfunction

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input string n, input logic [29:0] s, input logic [29:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] ad, input logic [29:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] ad, input logic [29:0] e, input string n);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata, e);
  endtask
  task automatic ld(input logic [29:0] a, input logic [29:0] q);
    wr(REG_ACC, a);
    wr(REG_SECOND, q);
  endtask
  task automatic ex(input logic [5:0] op, input logic [2:0] j, input logic [2:0] k, input logic [29:0] y);
    @(posedge clock);
    exec_start <= 1'b1;
    exec_op <= op;
    exec_j <= j;
    exec_k <= k;
    exec_operand <= y;
    exec_addr <= ADR ^ {9'h000, op};
    @(posedge clock);
    exec_start <= 1'b0;
    @(posedge clock);
    #1;
    chk("done", done, 30'h1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_arith;
    logic [5:0] op;
    logic st;
    for (int i = 20; i < 48; i++) begin
      op = i[5:0];
      if (op == 6'h1A || op == 6'h1B || op == 6'h27) continue;
      st = op inside {6'h14, 6'h15, [6'h1C:6'h1F], [6'h24:6'h26], [6'h2C:6'h2F]};
      ld(A0, Q0);
      ex(op, 3'h0, 3'h3, Y0);
      chk("mem_we", mem_we, st);
      if (st) begin
        chk("mem_wdata", mem_wdata, ea(op));
        chk("mem_addr", mem_addr, ADR ^ {9'h000, op});
      end
      rd(REG_ACC, ea(op), "acc");
      rd(REG_SECOND, op == 6'h16 ? oa(Q0, Y0) : op == 6'h17 ? os(Q0, Y0) : Q0, "second");
      if (st) chk("stored", look_data, ea(op));
    end
    $display("t_arith finished");
  endtask
  task automatic t_skip;
    logic [29:0] a, q;
    for (int i = 0; i < 32; i++) begin
      a = i[4] ? 30'h2000_0001 : 30'h0000_0007;
      q = i[4] ? 30'h0000_0000 : 30'h0000_0005;
      ld(a, q);
      ex(i[3] ? 6'h23 : 6'h16, i[2:0], 3'h3, 30'h0000_0000);
      chk("skip", skip, sk(i[2:0], i[3] ? os(a, 30'h0000_0000) : a, q));
    end
    $display("t_skip finished");
  endtask
  task automatic t_parity;
    for (int i = 0; i < 16; i++) begin
      ld(A0, 30'h3FFF_FFFF);
      ex(i[2] ? 6'h24 : 6'h20, {1'b0, i[1:0]}, 3'h3, i[3] ? 30'h0000_0007 : 30'h0000_0003);
      chk("skip", skip, i[1:0] == 1 || (i[1:0] == 2 && !i[3]) || (i[1:0] == 3 && i[3]));
    end
    $display("t_parity finished");
  endtask
  task automatic t_store;
    logic [5:0] op;
    logic [29:0] e;
    for (int i = 0; i < 9; i++) begin
      op = i < 3 ? 6'h1A : i < 6 ? 6'h1B : 6'h27;
      e = op == 6'h1A ? oa(A0, Q0) : op == 6'h1B ? os(A0, Q0) : A0 & Q0;
      ld(A0, Q0);
      ex(op, 3'h0, 3'(i % 3 + 1), Y0);
      chk("mem_be", mem_be, 30'(i % 3 + 1));
      if (i % 3 == 2) chk("mem_wdata", mem_wdata, e);
      rd(REG_ACC, op == 6'h27 ? A0 : e, "acc");
    end
    $display("t_store finished");
  endtask
  task automatic t_jump;
    logic [29:0] a, q;
    for (int i = 0; i < 16; i++) begin
      a = i[3] ? 30'h0000_0000 : 30'h2000_0003;
      q = i[3] ? 30'h2000_0000 : 30'h0000_0005;
      ld(a, q);
      wr(REG_CONTROL, 30'h0000_0002);
      ex(6'h30, i[2:0], 3'h3, 30'h1555_4321);
      chk("jump", jump, sk(i[2:0], q, a));
      if (sk(i[2:0], q, a)) chk("jump_addr", jump_addr, 30'h0000_4321);
      chk("int_enable", int_enable, i[2:1] == 0);
    end
    $display("t_jump finished");
  endtask
  task automatic t_keys;
    for (int i = 0; i < 16; i++) begin
      jump_keys <= i[3] ? 3'h5 : 3'h2;
      stop_keys <= i[3] ? 3'h2 : 3'h5;
      wr(REG_CONTROL, 30'h0000_0001);
      ex(6'h31, i[2:0], 3'h3, Y0);
      chk("jump", jump, i[2:0] == 0 || i[2:0] > 3 || jump_keys[i[1:0] - 1]);
      chk("halt", halt, i[2:0] == 4 || (i[2:0] > 4 && stop_keys[i[1:0] - 1]));
    end
    for (int i = 0; i < 16; i++) begin
      ibuf_active <= i[3] ? 8'h5A : 8'hA5;
      ex(6'h32, i[2:0], {1'b0, i[1:0]}, Y0);
      chk("jump", jump, ibuf_active[i[2:0]]);
    end
    $display("t_keys finished");
  endtask
  task automatic t_busy;
    ld(30'h0000_0000, Q0);
    @(posedge clock);
    exec_start <= 1'b1;
    exec_op <= 6'h28;
    exec_operand <= 30'h0000_0001;
    @(posedge clock);
    exec_op <= 6'h2A;
    exec_operand <= 30'h3FFF_FFFF;
    reg_wr <= 1'b1;
    reg_addr <= REG_ACC;
    reg_wdata <= 30'h0000_0055;
    #1;
    chk("busy", busy, 30'h1);
    @(posedge clock);
    exec_start <= 1'b0;
    reg_wr <= 1'b0;
    @(posedge clock);
    #1;
    chk("done", done, 30'h0);
    rd(REG_ACC, 30'h0000_0001, "acc");
    wr(REG_CONTROL, 30'h0000_0003);
    ex(6'h31, 3'h4, 3'h3, Y0);
    rd(REG_STATUS, 30'h0000_0014, "status");
    ex(6'h00, 3'h0, 3'h3, Y0);
    rd(REG_STATUS, 30'h0000_0024, "status");
    $display("t_busy finished");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (6000) @(posedge clock);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test;
  end
  initial begin
    {rstn, reg_wr, reg_rd, exec_start, reg_addr, reg_wdata, exec_op} = '0;
    {exec_j, exec_k, exec_operand, exec_addr, jump_keys, stop_keys, ibuf_active} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t_arith;
    t_skip;
    t_parity;
    t_store;
    t_jump;
    t_keys;
    t_busy;
    end_of_test;
  end
endmodule
